// ===== src/scb_bridge.sv
// Register bridge between a host register port and a scrubbing controller
//
// Function
// - Ready, CRC, ROM, uncorrectable, init error, heartbeat, log events: rising edge.
// - Correction-state and initialization-state sources trigger on falling edge.
// - Each source has an enable; reset enables ready, uncorrectable, correction, heartbeat.
// - Correction interrupt precedes uncorrectable; host services correction first.
// - Full error report is in log FIFO when correction interrupt asserts.
// - Uncorrectable flag sampled at correction fall tells correction from failure.
// - Ready interrupt follows finished initialization and an idle/detect/observe state.
// - Ready value register is final when ready interrupt asserts.
// - Report and command bytes pass through FIFOs; flags pass through registers.
// - Log FIFO holds reports: 8192 by 8, show-ahead, zero read latency.
// - Command FIFO: 1024 by 8, show-ahead, zero read latency.
// - No command starts until host writes one of eleven command bits.
// - Each command enters the command FIFO one byte per write.
// - One command bit starts a command; busy bit 27 holds until last byte queued.
// - All enabled pending sources merge into one interrupt output.
`timescale 1ns/10ps
`default_nettype none

module scb_bridge (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Controller status flags
  input wire logic ctl_ready_i,
  input wire logic [7:0] ready_value_i,
  input wire logic crc_found_i,
  input wire logic rom_found_i,
  input wire logic st_uncorr_i,
  input wire logic st_corr_i,
  input wire logic st_init_i,
  input wire logic init_err_i,
  input wire logic hb_timeout_i,
  // Report byte stream from controller
  input wire logic log_wr_i,
  input wire logic [scb_pkg::BYTE_W-1:0] log_data_i,
  // Command byte stream to controller
  output logic cmd_valid_o,
  output logic [scb_pkg::BYTE_W-1:0] cmd_data_o,
  input wire logic cmd_take_i,
  // Interrupt
  output logic irq_o
);

  import scb_pkg::*;

  // ***************************************************
  // Declarations
  // ***************************************************
  logic log_wr_ready;
  logic log_valid;
  logic [BYTE_W-1:0] log_head;
  logic log_pop;
  logic cmd_wr_valid;
  logic [BYTE_W-1:0] cmd_wr_data;
  logic cmd_wr_ready;
  logic cmd_fifo_valid;
  logic [BYTE_W-1:0] cmd_fifo_data;
  logic cmd_pop;
  logic overflow_q;
  logic underflow_q;
  logic [IRQ_COUNT-1:0] irq_raw;
  logic [IRQ_COUNT-1:0] irq_prev;
  logic [IRQ_COUNT-1:0] irq_edge;
  logic [IRQ_COUNT-1:0] irq_en;
  logic [IRQ_COUNT-1:0] irq_pend;
  logic [7:0] ready_value;
  logic corr_seen;
  logic corr_uncorr;
  scb_send_t send_state;
  logic [3:0] cmd_sel;
  logic [3:0] next_cmd_sel;
  logic cmd_onehot;
  logic cmd_start;
  logic wr_cmd;
  logic wr_pend;
  logic wr_en;
  logic rd_log;
  logic [31:0] next_rdata;

  // ***************************************************
  // Byte FIFOs
  // ***************************************************
  // Report log, overflowing bytes are dropped and flagged
  scb_fifo #(.AW(LOG_AW), .DW(BYTE_W)) u_log_fifo (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .wr_valid_i(log_wr_i),
    .wr_data_i(log_data_i),
    .wr_ready_o(log_wr_ready),
    .rd_valid_o(log_valid),
    .rd_data_o(log_head),
    .rd_take_i(log_pop)
  );

  // Command bytes toward the controller
  scb_fifo #(.AW(CMD_AW), .DW(BYTE_W)) u_cmd_fifo (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .wr_valid_i(cmd_wr_valid),
    .wr_data_i(cmd_wr_data),
    .wr_ready_o(cmd_wr_ready),
    .rd_valid_o(cmd_fifo_valid),
    .rd_data_o(cmd_fifo_data),
    .rd_take_i(cmd_pop)
  );

  // ***************************************************
  // Register decode
  // ***************************************************
  assign wr_cmd = reg_wr_i && (reg_addr_i == OFS_COMMAND);
  assign wr_pend = reg_wr_i && (reg_addr_i == OFS_IRQ_PEND);
  assign wr_en = reg_wr_i && (reg_addr_i == OFS_IRQ_EN);
  assign rd_log = reg_rd_i && (reg_addr_i == OFS_LOG_DATA);
  assign log_pop = rd_log && log_valid;

  // Read mux, unmapped offsets answer zero
  always_comb begin
    next_rdata = '0;
    unique case (reg_addr_i)
      OFS_COMMAND: next_rdata[BUSY_BIT] = (send_state != SCB_SEND_IDLE);
      OFS_READY: next_rdata[7:0] = ready_value;
      OFS_IRQ_PEND: next_rdata[IRQ_COUNT-1:0] = irq_pend;
      OFS_IRQ_EN: next_rdata[IRQ_COUNT-1:0] = irq_en;
      OFS_LOG_DATA: next_rdata[LOG_VALID_BIT:0] = {log_valid, log_head & {BYTE_W{log_valid}}}; // Empty reads zero
      OFS_STATUS: begin
        next_rdata[ST_LOG_EMPTY] = !log_valid;
        next_rdata[ST_LOG_FULL] = !log_wr_ready;
        next_rdata[ST_CMD_FULL] = !cmd_wr_ready;
        next_rdata[ST_CORR_SEEN] = corr_seen;
        next_rdata[ST_CORR_UNCORR] = corr_uncorr;
      end
      default: next_rdata = '0;
    endcase
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= '0;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= next_rdata;
      end
    end
  end

  // ***************************************************
  // Interrupt sources
  // ***************************************************
  // Log FIFO error events, registered as one-cycle pulses
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      overflow_q <= 1'b0;
      underflow_q <= 1'b0;
    end else begin
      overflow_q <= log_wr_i && !log_wr_ready;
      underflow_q <= rd_log && !log_valid;
    end
  end

  assign irq_raw = {log_valid, underflow_q, !log_wr_ready, overflow_q, hb_timeout_i,
                    init_err_i, st_init_i, st_corr_i, st_uncorr_i, rom_found_i,
                    crc_found_i, ctl_ready_i};

  // Rising edge unless the fall mask picks the falling edge
  assign irq_edge = (irq_raw ^ irq_prev) & (irq_raw ^ IRQ_FALL_MASK);

  // Previous source levels and the ready value, sampled together
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_prev <= '0;
      ready_value <= '0;
    end else begin
      irq_prev <= irq_raw;
      ready_value <= ready_value_i;
    end
  end

  // Enable register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_en <= IRQ_EN_RESET;
    end else if (wr_en) begin
      irq_en <= reg_wdata_i[IRQ_COUNT-1:0];
    end
  end

  // Pending flags: write one to clear, a new edge wins over the clear
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_pend <= '0;
    end else begin
      irq_pend <= (irq_pend & ~(wr_pend ? reg_wdata_i[IRQ_COUNT-1:0] : '0))
                  | (irq_edge & irq_en);
    end
  end

  // Merged interrupt line
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_pend & irq_en);
    end
  end

  // Outcome of the last pass through correction state
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      corr_seen <= 1'b0;
      corr_uncorr <= 1'b0;
    end else if (irq_edge[IRQ_CORR]) begin
      corr_seen <= 1'b1;
      corr_uncorr <= st_uncorr_i;
    end
  end

  // ***************************************************
  // Command sender
  // ***************************************************
  // Encode the written bit, accept only exactly one set
  always_comb begin
    next_cmd_sel = '0;
    for (int i = 0; i < CMD_COUNT; i++) begin
      if (reg_wdata_i[i]) begin
        next_cmd_sel = 4'(i);
      end
    end
  end

  assign cmd_onehot = (reg_wdata_i[CMD_COUNT-1:0] != '0)
    && ((reg_wdata_i[CMD_COUNT-1:0] & (reg_wdata_i[CMD_COUNT-1:0] - 1'b1)) == '0);
  assign cmd_start = wr_cmd && cmd_onehot && (send_state == SCB_SEND_IDLE);

  // One byte per FIFO write: letter, then terminator
  assign cmd_wr_valid = (send_state != SCB_SEND_IDLE);
  assign cmd_wr_data = (send_state == SCB_SEND_CHAR) ?
    CMD_LETTERS[{cmd_sel, 3'b000} +: 8] : CMD_TERM;

  // Sender state, busy until the terminator is queued
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      send_state <= SCB_SEND_IDLE;
      cmd_sel <= '0;
    end else begin
      unique case (send_state)
        SCB_SEND_IDLE: begin
          if (cmd_start) begin
            send_state <= SCB_SEND_CHAR;
            cmd_sel <= next_cmd_sel;
          end
        end
        SCB_SEND_CHAR: begin
          if (cmd_wr_ready) begin
            send_state <= SCB_SEND_TERM;
          end
        end
        SCB_SEND_TERM: begin
          if (cmd_wr_ready) begin
            send_state <= SCB_SEND_IDLE;
          end
        end
      endcase
    end
  end

  // ***************************************************
  // Command output register
  // ***************************************************
  assign cmd_pop = cmd_fifo_valid && (!cmd_valid_o || cmd_take_i);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_valid_o <= 1'b0;
      cmd_data_o <= '0;
    end else if (!cmd_valid_o || cmd_take_i) begin
      cmd_valid_o <= cmd_fifo_valid;
      cmd_data_o <= cmd_fifo_data;
    end
  end

endmodule // scb_bridge

`default_nettype wire

// ===== src/scb_fifo.sv
// Show-ahead byte FIFO with zero read latency
`timescale 1ns/10ps
`default_nettype none

module scb_fifo #(
  parameter int unsigned AW = 4,
  parameter int unsigned DW = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Fill side
  input wire logic wr_valid_i,
  input wire logic [DW-1:0] wr_data_i,
  output logic wr_ready_o,
  // Drain side
  output logic rd_valid_o,
  output logic [DW-1:0] rd_data_o,
  input wire logic rd_take_i
);

  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [AW:0] wptr;
  logic [AW:0] rptr;
  logic full;
  logic empty;

  // Flags from pointers with wrap bit
  assign full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  assign empty = (wptr == rptr);
  assign wr_ready_o = !full;
  assign rd_valid_o = !empty;
  assign rd_data_o = mem[rptr[AW-1:0]]; // Head shown ahead of the take

  // Storage write, no reset needed
  always_ff @(posedge clk_i) begin
    if (wr_valid_i && !full) begin
      mem[wptr[AW-1:0]] <= wr_data_i;
    end
  end

  // Pointer update
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (wr_valid_i && !full) begin
        wptr <= wptr + 1'b1;
      end
      if (rd_take_i && !empty) begin
        rptr <= rptr + 1'b1;
      end
    end
  end

endmodule // scb_fifo

`default_nettype wire

// ===== src/scb_pkg.sv
// Constants and types shared by the scrubber register bridge
package scb_pkg;

  // ***************************************************
  // Sizes
  // ***************************************************
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned CMD_COUNT = 11;
  localparam int unsigned IRQ_COUNT = 12;
  localparam int unsigned LOG_AW = 13; // 8192 entries
  localparam int unsigned CMD_AW = 10; // 1024 entries

  // ***************************************************
  // Register offsets (byte addresses)
  // ***************************************************
  localparam logic [7:0] OFS_COMMAND = 8'h00;
  localparam logic [7:0] OFS_READY = 8'h04;
  localparam logic [7:0] OFS_IRQ_PEND = 8'h08;
  localparam logic [7:0] OFS_IRQ_EN = 8'h0C;
  localparam logic [7:0] OFS_LOG_DATA = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // ***************************************************
  // Field positions and reset values
  // ***************************************************
  localparam int unsigned BUSY_BIT = 27;
  localparam int unsigned LOG_VALID_BIT = 8;
  localparam int unsigned ST_LOG_EMPTY = 0;
  localparam int unsigned ST_LOG_FULL = 1;
  localparam int unsigned ST_CMD_FULL = 2;
  localparam int unsigned ST_CORR_SEEN = 3;
  localparam int unsigned ST_CORR_UNCORR = 4;
  localparam int unsigned IRQ_READY = 0;
  localparam int unsigned IRQ_CORR = 4;
  localparam logic [11:0] IRQ_EN_RESET = 12'h099;
  localparam logic [11:0] IRQ_FALL_MASK = 12'h030;

  // ***************************************************
  // Command bytes: one letter per command bit, then carriage return
  // ***************************************************
  localparam logic [7:0] CMD_TERM = 8'h0D;
  localparam logic [CMD_COUNT*8-1:0] CMD_LETTERS =
    {8'h50, 8'h54, 8'h58, 8'h51, 8'h4E, 8'h52, 8'h55, 8'h53, 8'h44, 8'h4F, 8'h49};

  // Command sender states, Gray along idle -> letter -> terminator
  typedef enum logic [1:0] {
    SCB_SEND_IDLE = 2'b00,
    SCB_SEND_CHAR = 2'b01,
    SCB_SEND_TERM = 2'b11
  } scb_send_t;

endpackage

// ===== tb/scb_bridge_assertions.sv
// Port-level checker for the scrubber register bridge
`timescale 1ns/10ps
`default_nettype none

module scb_chk
  import scb_pkg::*;
(
  // Clock, reset and register port
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  // Flags, command stream and interrupt
  input wire logic ctl_ready_i,
  input wire logic st_corr_i,
  input wire logic cmd_valid_o,
  input wire logic [7:0] cmd_data_o,
  input wire logic cmd_take_i,
  input wire logic irq_o
);
  logic [11:0] en_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // Shadow of the enable register, to know which edges must raise irq
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) en_q <= IRQ_EN_RESET;
    else if (reg_wr_i && reg_addr_i == OFS_IRQ_EN) en_q <= reg_wdata_i[11:0];
  end

  a_read_answer: assert property (reg_rvalid_o == $past(reg_rd_i))
    else $error("read answer out of step");
  a_ready_raise: assert property ($rose(ctl_ready_i) && en_q[IRQ_READY] |-> ##[1:3] irq_o)
    else $error("ready edge gave no interrupt");
  a_corr_fall: assert property ($fell(st_corr_i) && en_q[IRQ_CORR] |-> ##[1:3] irq_o)
    else $error("correction fall gave no interrupt");
  a_masked_quiet: assert property (en_q == 12'h000 && $past(en_q) == 12'h000 |-> !irq_o)
    else $error("interrupt with all sources masked");
  a_cmd_cause: assert property ($rose(cmd_valid_o) |->
    $past(reg_wr_i, 2) || $past(reg_wr_i, 3) || $past(reg_wr_i, 4) || $past(reg_wr_i, 5))
    else $error("command byte without a write");
  a_cmd_stand: assert property (cmd_valid_o && !cmd_take_i |=> cmd_valid_o && $stable(cmd_data_o))
    else $error("command byte changed before taken");
  a_cmd_term: assert property (cmd_valid_o && cmd_take_i && cmd_data_o != CMD_TERM |=>
    cmd_valid_o && cmd_data_o == CMD_TERM)
    else $error("letter not followed by terminator");
  a_busy_seen: assert property (reg_wr_i && reg_addr_i == OFS_COMMAND && $onehot(reg_wdata_i[10:0])
    ##1 reg_rd_i && reg_addr_i == OFS_COMMAND |=> reg_rdata_o[BUSY_BIT])
    else $error("busy not set after command");

  // Main scenarios reached
  c_cmd_taken: cover property (cmd_valid_o && cmd_take_i);
  c_cmd_stall: cover property (cmd_valid_o && !cmd_take_i);
  c_irq_rise: cover property ($rose(irq_o));
endmodule // scb_chk

bind scb_bridge scb_chk u_chk (.clk_i, .rst_b_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
  .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .ctl_ready_i, .st_corr_i, .cmd_valid_o,
  .cmd_data_o, .cmd_take_i, .irq_o);

`default_nettype wire

// ===== tb/scb_ctl_model.sv
// Behavioural scrubbing controller at the far side of the bridge
`timescale 1ns/10ps
`default_nettype none

module scb_ctl_model (
  // Clock and pacing
  input wire logic clk_i,
  input wire logic slow_i,
  // Command bytes from the bridge
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_data_i,
  output logic cmd_take_o,
  // Report bytes toward the bridge
  output logic log_wr_o,
  output logic [7:0] log_data_o
);
  logic [7:0] rx_q[$];

  // Idle levels at time zero
  initial begin
    cmd_take_o = 1'h0;
    log_wr_o = 1'h0;
    log_data_o = 8'h00;
  end

  // Take command bytes unless stalled, keeping their order
  always @(posedge clk_i) begin
    if (cmd_valid_i && cmd_take_o) rx_q.push_back(cmd_data_i);
    cmd_take_o <= !slow_i;
  end

  // One report byte, then the data lines no longer hold it
  task automatic send_log(input logic [7:0] b);
    log_wr_o = 1'h1;
    log_data_o = b;
    @(negedge clk_i);
    log_wr_o = 1'h0;
    log_data_o = ~b;
    @(negedge clk_i);
  endtask
endmodule // scb_ctl_model

`default_nettype wire

// ===== tb/test_scb_bridge.sv
// Self-checking testbench for the scrubber register bridge
`timescale 1ns/10ps
`default_nettype none

module test_scb_bridge;
  import scb_pkg::*;
  logic clk_i = 1'h0, rst_b_i = 1'h0, reg_wr_i = 1'h0, reg_rd_i = 1'h0, slow = 1'h0;
  logic [7:0] reg_addr_i = 8'h00, ready_value_i = 8'h00, log_data_i, cmd_data_o;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, rdv;
  logic ctl_ready_i = 1'h0, crc_found_i = 1'h0, rom_found_i = 1'h0, st_uncorr_i = 1'h0;
  logic st_corr_i = 1'h0, st_init_i = 1'h0, init_err_i = 1'h0, hb_timeout_i = 1'h0;
  logic log_wr_i, reg_rvalid_o, cmd_valid_o, cmd_take_i, irq_o;
  int err_total = 0, check_count = 0, cyc = 0;

  // Clock and the cycle ceiling
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end

  scb_bridge u_dut (.clk_i, .rst_b_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
    .reg_rdata_o, .reg_rvalid_o, .ctl_ready_i, .ready_value_i, .crc_found_i, .rom_found_i,
    .st_uncorr_i, .st_corr_i, .st_init_i, .init_err_i, .hb_timeout_i, .log_wr_i,
    .log_data_i, .cmd_valid_o, .cmd_data_o, .cmd_take_i, .irq_o);
  scb_ctl_model u_ctl (.clk_i, .slow_i(slow), .cmd_valid_i(cmd_valid_o),
    .cmd_data_i(cmd_data_o), .cmd_take_o(cmd_take_i), .log_wr_o(log_wr_i),
    .log_data_o(log_data_i));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Register write strobe, one cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_wr_i = 1'h1;
    reg_addr_i = a;
    reg_wdata_i = v;
    @(negedge clk_i);
    reg_wr_i = 1'h0;
  endtask

  // Register read, waiting a bounded time for the answer
  task automatic rd(input logic [7:0] a);
    int n = 0;
    reg_rd_i = 1'h1;
    reg_addr_i = a;
    @(negedge clk_i);
    reg_rd_i = 1'h0;
    while (reg_rvalid_o !== 1'h1 && n < 3) begin
      @(negedge clk_i);
      n++;
    end
    rdv = reg_rdata_o;
    @(negedge clk_i);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    cmp(rdv, exp);
  endtask

  task automatic irq_wait;
    int n = 0;
    while (irq_o !== 1'h1 && n < 5) begin
      @(negedge clk_i);
      n++;
    end
    cmp({31'h0, irq_o}, 32'h1);
  endtask

  task automatic t_reset;
    rdc(OFS_IRQ_EN, 32'h099);
    rdc(OFS_STATUS, 32'h001);
    rdc(OFS_IRQ_PEND, 32'h0);
    rdc(8'h20, 32'h0);
    $display("reset values done");
  endtask

  task automatic t_ready;
    ready_value_i = 8'h5A;
    ctl_ready_i = 1'h1;
    irq_wait();
    rdc(OFS_READY, 32'h05A);
    rdc(OFS_IRQ_PEND, 32'h001);
    wr(OFS_IRQ_PEND, 32'h001);
    rdc(OFS_IRQ_PEND, 32'h0);
    cmp({31'h0, irq_o}, 32'h0);
    $display("ready interrupt done");
  endtask

  task automatic t_corr;
    u_ctl.send_log(8'h45);
    u_ctl.send_log(8'h0D);
    st_corr_i = 1'h1;
    repeat (4) @(negedge clk_i);
    rdc(OFS_IRQ_PEND, 32'h0);
    st_corr_i = 1'h0;
    irq_wait();
    rdc(OFS_LOG_DATA, 32'h145);
    rdc(OFS_LOG_DATA, 32'h10D);
    rdc(OFS_STATUS, 32'h009);
    st_uncorr_i = 1'h1;
    repeat (4) @(negedge clk_i);
    rdc(OFS_IRQ_PEND, 32'h018);
    st_corr_i = 1'h1;
    repeat (4) @(negedge clk_i);
    st_corr_i = 1'h0;
    repeat (4) @(negedge clk_i);
    rdc(OFS_STATUS, 32'h019);
    wr(OFS_IRQ_PEND, 32'h018);
    rdc(OFS_IRQ_PEND, 32'h0);
    $display("correction sequence done");
  endtask

  task automatic t_mask;
    wr(OFS_IRQ_EN, 32'h0);
    hb_timeout_i = 1'h1;
    repeat (4) @(negedge clk_i);
    cmp({31'h0, irq_o}, 32'h0);
    rdc(OFS_IRQ_PEND, 32'h0);
    wr(OFS_IRQ_EN, 32'hFFF);
    rdc(OFS_IRQ_EN, 32'hFFF);
    st_init_i = 1'h1;
    repeat (4) @(negedge clk_i);
    {crc_found_i, rom_found_i, init_err_i, st_init_i} = 4'hE;
    irq_wait();
    rdc(OFS_IRQ_PEND, 32'h066);
    rdc(OFS_LOG_DATA, 32'h0);
    rdc(OFS_IRQ_PEND, 32'h466);
    u_ctl.send_log(8'h21);
    rdc(OFS_IRQ_PEND, 32'hC66);
    rdc(OFS_LOG_DATA, 32'h121);
    wr(OFS_IRQ_PEND, 32'hFFF);
    rdc(OFS_IRQ_PEND, 32'h0);
    $display("masking done");
  endtask

  task automatic t_cmd;
    int n;
    for (int i = 0; i < CMD_COUNT; i++) begin
      u_ctl.rx_q.delete();
      slow = i[0];
      wr(OFS_COMMAND, 32'h1 << i);
      rd(OFS_COMMAND);
      cmp(rdv & 32'h0800_0000, 32'h0800_0000);
      repeat (8) @(negedge clk_i);
      slow = 1'h0;
      n = 0;
      while (u_ctl.rx_q.size() < 2 && n < 40) begin
        @(negedge clk_i);
        n++;
      end
      cmp({24'h0, u_ctl.rx_q[0]}, {24'h0, CMD_LETTERS[i*8 +: 8]});
      cmp({24'h0, u_ctl.rx_q[1]}, {24'h0, CMD_TERM});
      rd(OFS_COMMAND);
      cmp(rdv & 32'h0800_0000, 32'h0);
    end
    u_ctl.rx_q.delete();
    wr(OFS_COMMAND, 32'h003);
    rd(OFS_COMMAND);
    cmp(rdv & 32'h0800_0000, 32'h0);
    wr(OFS_COMMAND, 32'h001);
    @(negedge clk_i);
    wr(OFS_COMMAND, 32'h004);
    repeat (30) @(negedge clk_i);
    cmp(32'(u_ctl.rx_q.size()), 32'h2);
    cmp({24'h0, u_ctl.rx_q[0]}, {24'h0, CMD_LETTERS[7:0]});
    $display("commands done");
  endtask

  // Fill the log to its depth, then one byte more
  task automatic t_full;
    for (int i = 0; i <= 8192; i++) begin
      u_ctl.send_log(i[7:0]);
    end
    rdc(OFS_IRQ_PEND, 32'hB00);
    rdc(OFS_STATUS, 32'h01A);
    rdc(OFS_LOG_DATA, 32'h100);
    rdc(OFS_LOG_DATA, 32'h101);
    $display("log depth done");
  endtask

  // Reset, then the scenarios in turn
  initial begin
    repeat (16) @(posedge clk_i);
    @(negedge clk_i);
    rst_b_i = 1'h1;
    @(negedge clk_i);
    t_reset();
    t_ready();
    t_corr();
    t_mask();
    t_cmd();
    t_full();
    results();
  end
endmodule // test_scb_bridge

`default_nettype wire
